// ===== hw/egs_consts.svh
`ifndef EGS_CONSTS_SVH
`define EGS_CONSTS_SVH

// register byte offsets
`define EGS_OFF_NUM      8'h00
`define EGS_OFF_DEN      8'h04
`define EGS_OFF_UNIT     8'h08
`define EGS_OFF_FACTOR   8'h0C
`define EGS_OFF_CTRL     8'h10
`define EGS_OFF_SPD_LIM  8'h14
`define EGS_OFF_FRQ_LIM  8'h18
`define EGS_OFF_STATUS   8'h1C
`define EGS_OFF_MASK     8'h20
`define EGS_OFF_OD_SUB   8'h24
`define EGS_OFF_OD_DATA  8'h28

// reset values
`define EGS_RST_RATIO    32'h0000_0001
`define EGS_RST_UNIT     2'h3
`define EGS_RST_LIMIT    32'hFFFF_FFFF

// unit codes and conversion factors
`define EGS_UNIT_MM      2'h0
`define EGS_UNIT_INCH    2'h1
`define EGS_UNIT_DEG     2'h2
`define EGS_UNIT_PULSE   2'h3
`define EGS_ALPHA_MM     32'h0000_03E8
`define EGS_ALPHA_INCH   32'h0000_2710
`define EGS_ALPHA_ONE    32'h0000_0001

// status bit positions
`define EGS_ST_OVERSPD   0
`define EGS_ST_CMDFRQ    1
`define EGS_ST_BADSET    2
`define EGS_ST_OVF       3
`define EGS_ST_W         4

// object dictionary subindices
`define EGS_SUB_COUNT    8'h00
`define EGS_SUB_NUM      8'h01
`define EGS_SUB_DEN      8'h02

// rate supervision window
`define EGS_WIN_NS       1000000
`define EGS_CLK_NS       25
`define EGS_WIN_CYCLES   (`EGS_WIN_NS / `EGS_CLK_NS)

`endif

// ===== hw/egs_gear_top.sv
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`include "egs_consts.svh"
`default_nettype none
// Function
// (RULE1) command delta times numerator over denominator
// (RULE2) feedback scaled by denominator over numerator
// (RULE3) two settable ratio terms, both reset one
// (RULE4) degree unit: teeth counts in ratio
// (RULE5) unit factor 1000 mm, 10000 inch, 1
// (RULE6) host reduces and rounds values before writing
// (RULE7) dictionary subindex 1 and 2 mirror ratio
// (RULE8) alarm when scaled command rate exceeds limit
// (RULE9) ratio changed only while servo off
// (RULE10) numerator above 2147483647 rejected
module egs_gear_top #(
   parameter int unsigned WIN_CYCLES = `EGS_WIN_CYCLES
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic         [7:0] wb_adr_i,
   input  wire logic         [3:0] wb_sel_i,
   input  wire logic        [31:0] wb_dat_i,
   output logic             [31:0] wb_dat_o,
   output logic                    wb_ack_o,
   // position command from controller
   input  wire logic               cmd_valid_i,
   input  wire logic signed [31:0] cmd_delta_i,
   output logic                    cmd_ready_o,
   // scaled motor target
   output logic                    pos_valid_o,
   output logic signed [31:0]      pos_delta_o,
   // motor feedback in, command-unit feedback out
   input  wire logic               fb_valid_i,
   input  wire logic signed [31:0] fb_delta_i,
   output logic                    fb_ready_o,
   output logic                    fb_cmd_valid_o,
   output logic signed [31:0]      fb_cmd_delta_o,
   // alarms and status
   output logic                    overspeed_alarm_o,
   output logic                    command_frequency_alarm_o,
   output logic                    irq_o,
   output egs_pkg::egs_state_type  engine_state_o
);
   import egs_pkg::*;

   localparam int unsigned SW = `EGS_ST_W;

   // register state
   logic        [31:0] num_q, num_d, den_q, den_d;
   logic         [1:0] unit_q, unit_d;
   logic               servo_on_q, servo_on_d;
   logic        [31:0] spd_lim_q, spd_lim_d, frq_lim_q, frq_lim_d;
   logic      [SW-1:0] status_q, status_d, mask_q, mask_d;
   logic         [7:0] od_sub_q, od_sub_d;
   logic        [31:0] rdata_d, factor, wval, old_val;
   logic               ack_d, irq_d, wr_take, wr_num, wr_den;
   logic               bad_set;
   logic      [SW-1:0] ev_set, w1c;

   // engine state
   egs_state_type      state_q, state_d;
   logic               cpend_q, cpend_d, fpend_q, fpend_d;
   logic signed [31:0] cdat_q, cdat_d, fdat_q, fdat_d;
   logic signed [31:0] crem_q, crem_d, frem_q, frem_d;
   logic signed [31:0] pos_d, fbc_d;
   logic               pos_v_d, fbc_v_d, ovf_ev;
   logic               md_start;
   logic signed [31:0] md_a, md_rem;
   logic        [30:0] md_b, md_div;
   logic               md_done;
   logic signed [63:0] md_quot;
   logic signed [31:0] md_rem_out;
   logic signed [31:0] sat_quot;

   // window tick
   logic        [31:0] win_cnt_q, win_cnt_d;
   logic               tick_q, tick_d;
   logic               spd_trip, frq_trip;

   function automatic logic [31:0] mag32(input logic signed [31:0] v);
      mag32 = v[31] ? 32'(-v) : 32'(v);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      merge = r;
   endfunction

   // conversion factor per unit; degree mode takes teeth counts as is
   always_comb begin
      unique case (unit_q)
         `EGS_UNIT_MM:   factor = `EGS_ALPHA_MM;   // RULE5
         `EGS_UNIT_INCH: factor = `EGS_ALPHA_INCH; // RULE5
         `EGS_UNIT_DEG:  factor = `EGS_ALPHA_ONE;  // RULE4
         `EGS_UNIT_PULSE: factor = `EGS_ALPHA_ONE; // RULE5
      endcase
   end

   // ---------------- register file ----------------
   always_comb begin
      // write lands on the edge where the master sees ack
      wr_take = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
      ack_d   = wb_cyc_i && wb_stb_i && !wb_ack_o;
      wr_num  = (wb_adr_i == `EGS_OFF_NUM) ||
                (wb_adr_i == `EGS_OFF_OD_DATA &&
                 od_sub_q == `EGS_SUB_NUM);                 // RULE7
      wr_den  = (wb_adr_i == `EGS_OFF_DEN) ||
                (wb_adr_i == `EGS_OFF_OD_DATA &&
                 od_sub_q == `EGS_SUB_DEN);                 // RULE7
      old_val = wr_num ? num_q : den_q;
      wval    = merge(old_val, wb_dat_i, wb_sel_i);

      num_d      = num_q;
      den_d      = den_q;
      unit_d     = unit_q;
      servo_on_d = servo_on_q;
      spd_lim_d  = spd_lim_q;
      frq_lim_d  = frq_lim_q;
      mask_d     = mask_q;
      od_sub_d   = od_sub_q;
      w1c        = '0;
      bad_set    = 1'b0;

      if (wr_take) begin
         if (wr_num || wr_den) begin
            // zero would divide by zero; bit 31 is out of range
            if (wval == 32'h0000_0000 || wval[31]) begin
               bad_set = 1'b1;                              // RULE10
            end else if (servo_on_q) begin
               // a half-written ratio would jerk a running axis
               bad_set = 1'b1;                              // RULE9
            end else if (wr_num) begin
               num_d = wval;                                // RULE3
            end else begin
               den_d = wval;                                // RULE3
            end
         end
         unique case (wb_adr_i)
            `EGS_OFF_UNIT: begin
               if (wb_sel_i[0]) begin
                  unit_d = wb_dat_i[1:0];
               end
            end
            `EGS_OFF_CTRL: begin
               if (wb_sel_i[0]) begin
                  servo_on_d = wb_dat_i[0];
               end
            end
            `EGS_OFF_SPD_LIM: spd_lim_d = merge(spd_lim_q, wb_dat_i,
                                                wb_sel_i);
            `EGS_OFF_FRQ_LIM: frq_lim_d = merge(frq_lim_q, wb_dat_i,
                                                wb_sel_i);
            `EGS_OFF_STATUS: begin
               if (wb_sel_i[0]) begin
                  w1c = wb_dat_i[SW-1:0];
               end
            end
            `EGS_OFF_MASK: begin
               if (wb_sel_i[0]) begin
                  mask_d = wb_dat_i[SW-1:0];
               end
            end
            `EGS_OFF_OD_SUB: begin
               if (wb_sel_i[0]) begin
                  od_sub_d = wb_dat_i[7:0];
               end
            end
            default: ;
         endcase
      end

      ev_set = '0;
      ev_set[`EGS_ST_OVERSPD] = spd_trip;                   // RULE8
      ev_set[`EGS_ST_CMDFRQ]  = frq_trip;                   // RULE8
      ev_set[`EGS_ST_BADSET]  = bad_set;
      ev_set[`EGS_ST_OVF]     = ovf_ev;
      // a new event beats a clear in the same cycle
      status_d = (status_q & ~w1c) | ev_set;
      irq_d    = |(status_d & mask_d);

      rdata_d = 32'h0000_0000;
      unique case (wb_adr_i)
         `EGS_OFF_NUM:     rdata_d = num_q;
         `EGS_OFF_DEN:     rdata_d = den_q;
         `EGS_OFF_UNIT:    rdata_d = {30'h0000_0000, unit_q};
         `EGS_OFF_FACTOR:  rdata_d = factor;                 // RULE5
         `EGS_OFF_CTRL:    rdata_d = {31'h0000_0000, servo_on_q};
         `EGS_OFF_SPD_LIM: rdata_d = spd_lim_q;
         `EGS_OFF_FRQ_LIM: rdata_d = frq_lim_q;
         `EGS_OFF_STATUS:  rdata_d = 32'(status_q);
         `EGS_OFF_MASK:    rdata_d = 32'(mask_q);
         `EGS_OFF_OD_SUB:  rdata_d = {24'h00_0000, od_sub_q};
         `EGS_OFF_OD_DATA: begin
            unique case (od_sub_q)
               `EGS_SUB_COUNT: rdata_d = 32'h0000_0002;
               `EGS_SUB_NUM:   rdata_d = num_q;              // RULE7
               `EGS_SUB_DEN:   rdata_d = den_q;              // RULE7
               default:        rdata_d = 32'h0000_0000;
            endcase
         end
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         num_q      <= `EGS_RST_RATIO;                      // RULE3
         den_q      <= `EGS_RST_RATIO;                      // RULE3
         unit_q     <= `EGS_RST_UNIT;
         servo_on_q <= 1'b0;
         spd_lim_q  <= `EGS_RST_LIMIT;
         frq_lim_q  <= `EGS_RST_LIMIT;
         status_q   <= '0;
         mask_q     <= '0;
         od_sub_q   <= 8'h00;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0000_0000;
         irq_o      <= 1'b0;
      end else begin
         num_q      <= num_d;
         den_q      <= den_d;
         unit_q     <= unit_d;
         servo_on_q <= servo_on_d;
         spd_lim_q  <= spd_lim_d;
         frq_lim_q  <= frq_lim_d;
         status_q   <= status_d;
         mask_q     <= mask_d;
         od_sub_q   <= od_sub_d;
         wb_ack_o   <= ack_d;
         wb_dat_o   <= rdata_d;
         irq_o      <= irq_d;
      end
   end

   // ---------------- scaling engine ----------------
   // one shared divider; commands take priority over feedback
   always_comb begin
      sat_quot = md_quot[31:0];
      ovf_ev   = 1'b0;
      if (md_done && (md_quot > 64'sh0000_0000_7FFF_FFFF ||
                      md_quot < -64'sh0000_0000_8000_0000)) begin
         sat_quot = md_quot[63] ? 32'sh8000_0000 : 32'sh7FFF_FFFF;
         ovf_ev   = 1'b1;
      end

      state_d  = state_q;
      cpend_d  = cpend_q;
      fpend_d  = fpend_q;
      cdat_d   = cdat_q;
      fdat_d   = fdat_q;
      crem_d   = crem_q;
      frem_d   = frem_q;
      pos_d    = pos_delta_o;
      fbc_d    = fb_cmd_delta_o;
      pos_v_d  = 1'b0;
      fbc_v_d  = 1'b0;
      md_start = 1'b0;
      md_a     = cdat_q;
      md_b     = num_q[30:0];
      md_div   = den_q[30:0];
      md_rem   = crem_q;

      if (cmd_valid_i && cmd_ready_o) begin
         cpend_d = 1'b1;
         cdat_d  = cmd_delta_i;
      end
      if (fb_valid_i && fb_ready_o) begin
         fpend_d = 1'b1;
         fdat_d  = fb_delta_i;
      end

      unique case (state_q)
         ST_IDLE: begin
            if (cpend_q) begin
               md_start = 1'b1;                             // RULE1
               state_d  = ST_CMD;
            end else if (fpend_q) begin
               md_a     = fdat_q;
               md_b     = den_q[30:0];                      // RULE2
               md_div   = num_q[30:0];                      // RULE2
               md_rem   = frem_q;
               md_start = 1'b1;
               state_d  = ST_FB;
            end
         end
         ST_CMD: begin
            if (md_done) begin
               pos_d   = sat_quot;                          // RULE1
               pos_v_d = 1'b1;
               crem_d  = md_rem_out;
               cpend_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
         ST_FB: begin
            if (md_done) begin
               fbc_d   = sat_quot;                          // RULE2
               fbc_v_d = 1'b1;
               frem_d  = md_rem_out;
               fpend_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
      endcase

      // stale remainders would exceed a new, smaller divisor
      if (num_d != num_q || den_d != den_q) begin
         crem_d = 32'sh0000_0000;
         frem_d = 32'sh0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q        <= ST_IDLE;
         cpend_q        <= 1'b0;
         fpend_q        <= 1'b0;
         cdat_q         <= 32'sh0000_0000;
         fdat_q         <= 32'sh0000_0000;
         crem_q         <= 32'sh0000_0000;
         frem_q         <= 32'sh0000_0000;
         pos_delta_o    <= 32'sh0000_0000;
         pos_valid_o    <= 1'b0;
         fb_cmd_delta_o <= 32'sh0000_0000;
         fb_cmd_valid_o <= 1'b0;
         cmd_ready_o    <= 1'b0;
         fb_ready_o     <= 1'b0;
         engine_state_o <= ST_IDLE;
      end else begin
         state_q        <= state_d;
         cpend_q        <= cpend_d;
         fpend_q        <= fpend_d;
         cdat_q         <= cdat_d;
         fdat_q         <= fdat_d;
         crem_q         <= crem_d;
         frem_q         <= frem_d;
         pos_delta_o    <= pos_d;
         pos_valid_o    <= pos_v_d;
         fb_cmd_delta_o <= fbc_d;
         fb_cmd_valid_o <= fbc_v_d;
         cmd_ready_o    <= !cpend_d;
         fb_ready_o     <= !fpend_d;
         engine_state_o <= state_d;
      end
   end

   egs_mul_div u_mul_div (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .start_i   (md_start),
      .mult_a_i  (md_a),
      .mult_b_i  (md_b),
      .divisor_i (md_div),
      .rem_i     (md_rem),
      .done_o    (md_done),
      .quot_o    (md_quot),
      .rem_o     (md_rem_out)
   );

   // ---------------- rate supervision ----------------
   always_comb begin
      win_cnt_d = win_cnt_q + 32'h0000_0001;
      tick_d    = 1'b0;
      if (win_cnt_q == 32'(WIN_CYCLES - 1)) begin
         win_cnt_d = 32'h0000_0000;
         tick_d    = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_cnt_q                 <= 32'h0000_0000;
         tick_q                    <= 1'b0;
         overspeed_alarm_o         <= 1'b0;
         command_frequency_alarm_o <= 1'b0;
      end else begin
         win_cnt_q                 <= win_cnt_d;
         tick_q                    <= tick_d;
         overspeed_alarm_o         <= status_d[`EGS_ST_OVERSPD];
         command_frequency_alarm_o <= status_d[`EGS_ST_CMDFRQ];
      end
   end

   // motor-side pulses after the ratio: overspeed
   egs_rate_mon u_spd_mon (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .valid_i (pos_valid_o),
      .mag_i   (mag32(pos_delta_o)),
      .tick_i  (tick_q),
      .limit_i (spd_lim_q),
      .trip_o  (spd_trip)
   );

   // controller-side command pulses: command frequency
   egs_rate_mon u_frq_mon (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .valid_i (cmd_valid_i && cmd_ready_o),
      .mag_i   (mag32(cmd_delta_i)),
      .tick_i  (tick_q),
      .limit_i (frq_lim_q),
      .trip_o  (frq_trip)
   );
endmodule
`default_nettype wire

// ===== hw/egs_mul_div.sv
`default_nettype none
// computes (a * b + rem) / d, truncated toward zero, bit serial
module egs_mul_div (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // request
   input  wire logic               start_i,
   input  wire logic signed [31:0] mult_a_i,
   input  wire logic        [30:0] mult_b_i,
   input  wire logic        [30:0] divisor_i,
   input  wire logic signed [31:0] rem_i,
   // result
   output logic                    done_o,
   output logic signed [63:0]      quot_o,
   output logic signed [31:0]      rem_o
);
   logic        [63:0] dvd_q, dvd_d;
   logic        [32:0] acc_q, acc_d;
   logic        [30:0] dsr_q, dsr_d;
   logic         [6:0] cnt_q, cnt_d;
   logic               neg_q, neg_d, run_q, run_d, done_d;
   logic signed [63:0] prod;
   logic        [32:0] trial;

   always_comb begin
      prod   = mult_a_i * $signed({33'h0_0000_0000, mult_b_i})
               + 64'(rem_i);
      trial  = {acc_q[31:0], dvd_q[63]};
      dvd_d  = dvd_q;
      acc_d  = acc_q;
      dsr_d  = dsr_q;
      cnt_d  = cnt_q;
      neg_d  = neg_q;
      run_d  = run_q;
      done_d = 1'b0;
      if (start_i && !run_q) begin
         neg_d = prod[63];
         dvd_d = prod[63] ? 64'(-prod) : 64'(prod);
         acc_d = 33'h0_0000_0000;
         dsr_d = divisor_i;
         cnt_d = 7'h00;
         run_d = 1'b1;
      end else if (run_q) begin
         dvd_d = {dvd_q[62:0], 1'b0};
         if (trial >= {2'b00, dsr_q}) begin
            acc_d    = trial - {2'b00, dsr_q};
            dvd_d[0] = 1'b1;
         end else begin
            acc_d = trial;
         end
         cnt_d = cnt_q + 7'h01;
         if (cnt_q == 7'h3F) begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dvd_q  <= 64'h0000_0000_0000_0000;
         acc_q  <= 33'h0_0000_0000;
         dsr_q  <= 31'h0000_0001;
         cnt_q  <= 7'h00;
         neg_q  <= 1'b0;
         run_q  <= 1'b0;
         done_o <= 1'b0;
      end else begin
         dvd_q  <= dvd_d;
         acc_q  <= acc_d;
         dsr_q  <= dsr_d;
         cnt_q  <= cnt_d;
         neg_q  <= neg_d;
         run_q  <= run_d;
         done_o <= done_d;
      end
   end

   assign quot_o = neg_q ? -$signed(dvd_q) : $signed(dvd_q);
   assign rem_o  = neg_q ? -$signed(acc_q[31:0]) : $signed(acc_q[31:0]);
endmodule
`default_nettype wire

// ===== hw/egs_pkg.sv
`default_nettype none
package egs_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CMD  = 3'b010,
      ST_FB   = 3'b100
   } egs_state_type;
endpackage
`default_nettype wire

// ===== hw/egs_rate_mon.sv
`default_nettype none
// sums magnitudes over one window, trips when the sum passes the limit
module egs_rate_mon (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // sample stream
   input  wire logic        valid_i,
   input  wire logic [31:0] mag_i,
   input  wire logic        tick_i,
   input  wire logic [31:0] limit_i,
   // alarm event
   output logic             trip_o
);
   logic [32:0] sum_q, sum_d, add;
   logic        trip_d;

   always_comb begin
      add    = {1'b0, sum_q[31:0]} + {1'b0, (valid_i ? mag_i : 32'h0)};
      // saturate so a long burst cannot wrap back under the limit
      sum_d  = add[32] ? 33'h0_FFFF_FFFF : add;
      trip_d = 1'b0;
      if (sum_d[31:0] > limit_i) begin
         trip_d = 1'b1;
      end
      if (tick_i) begin
         sum_d = 33'h0_0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sum_q  <= 33'h0_0000_0000;
         trip_o <= 1'b0;
      end else begin
         sum_q  <= sum_d;
         trip_o <= trip_d;
      end
   end
endmodule
`default_nettype wire

// ===== test/egs_ctl_model.sv
`default_nettype none
// upstream controller, one request in flight
module egs_ctl_model (
   // clock
   input  wire logic          clk_i,
   // readiness from the scaler
   input  wire logic          cmd_ready_i,
   input  wire logic          fb_ready_i,
   // requests
   output logic               cmd_valid_o = 1'b0,
   output logic signed [31:0] cmd_delta_o = 32'h0000_0000,
   output logic               fb_valid_o = 1'b0,
   output logic signed [31:0] fb_delta_o = 32'h0000_0000
);
   timeunit 1ns;
   timeprecision 100ps;
   task automatic send(input bit f, input logic signed [31:0] d,
                       output bit ok);
      int n;
      @(posedge clk_i);
      if (f) fb_valid_o <= 1'b1;
      else cmd_valid_o <= 1'b1;
      if (f) fb_delta_o <= d;
      else cmd_delta_o <= d;
      ok = 1'b0;
      for (n = 0; n < 300 && !ok; n++) begin
         @(posedge clk_i);
         ok = f ? fb_ready_i === 1'b1 : cmd_ready_i === 1'b1;
      end
      // released lines show the inverse, never a stale copy
      if (f) fb_delta_o <= ~d;
      else cmd_delta_o <= ~d;
      fb_valid_o <= 1'b0;
      cmd_valid_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== test/egs_gear_monitor.sv
`default_nettype none
module egs_gear_monitor (
   // clock and reset
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   // watched ports
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic                   wb_ack_o,
   input wire logic                   cmd_valid_i,
   input wire logic                   cmd_ready_o,
   input wire logic                   pos_valid_o,
   input wire logic                   fb_valid_i,
   input wire logic                   fb_ready_o,
   input wire logic                   fb_cmd_valid_o,
   input wire logic                   overspeed_alarm_o,
   input wire egs_pkg::egs_state_type engine_state_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import egs_pkg::*;
   // a feedback job may run ahead of a command
   localparam int MAX_LAT = 150;
   logic wr;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("bus answer late");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_cmd_take: assert property (cmd_valid_i && cmd_ready_o
      |=> !cmd_ready_o) else $error("ready held after take");
   chk_pos_bound: assert property (cmd_valid_i && cmd_ready_o
      |-> ##[1:MAX_LAT] pos_valid_o) else $error("no motor target");
   chk_pos_single: assert property (pos_valid_o |=> !pos_valid_o)
      else $error("target pulse too long");
   chk_fb_bound: assert property (fb_valid_i && fb_ready_o
      |-> ##[1:MAX_LAT] fb_cmd_valid_o) else $error("no feedback result");
   chk_alarm_sticky: assert property (overspeed_alarm_o && !wr
      && !$past(wr) |=> overspeed_alarm_o) else $error("alarm not sticky");
   chk_state_onehot: assert property ($onehot(engine_state_o))
      else $error("state not one-hot");
endmodule
`default_nettype wire

// ===== test/electronic_gear_scaler_tb.sv
`include "egs_consts.svh"
`default_nettype none
module electronic_gear_scaler_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import egs_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, pos_d, fbc_d, cmd_d, fb_d;
   logic ack, cmd_v, cmd_rdy, pos_v, fb_v, fb_rdy, fbc_v, ovs, cfa, irq;
   egs_state_type state;
   int err_total = 0, checks_done = 0, i;
   logic [31:0] fac [4] = '{32'h0000_03E8, 32'h0000_2710,
                            32'h0000_0001, 32'h0000_0001};
   always #12.5 clk = ~clk;
   egs_gear_top #(.WIN_CYCLES(64)) dut (.clk_i(clk), .rst_i(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .cmd_valid_i(cmd_v), .cmd_delta_i(cmd_d), .cmd_ready_o(cmd_rdy),
      .pos_valid_o(pos_v), .pos_delta_o(pos_d), .fb_valid_i(fb_v),
      .fb_delta_i(fb_d), .fb_ready_o(fb_rdy), .fb_cmd_valid_o(fbc_v),
      .fb_cmd_delta_o(fbc_d), .overspeed_alarm_o(ovs),
      .command_frequency_alarm_o(cfa), .irq_o(irq),
      .engine_state_o(state));
   egs_ctl_model ctl (.clk_i(clk), .cmd_ready_i(cmd_rdy),
      .fb_ready_i(fb_rdy), .cmd_valid_o(cmd_v), .cmd_delta_o(cmd_d),
      .fb_valid_o(fb_v), .fb_delta_o(fb_d));
   task automatic stop_test(input bit hang);
      if (hang) err_total++;
      if (hang) $display("[FAIL] %0t wait ran out", $time);
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) err_total++;
      if (got !== exp) $display("[FAIL] %0t got %h want %h", $time, got,
                                exp);
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) stop_test(1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask
   task automatic move(input bit f, input logic [31:0] d,
                       input logic [31:0] e);
      bit ok;
      int n;
      ctl.send(f, d, ok);
      if (!ok) stop_test(1'b1);
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if ((f ? fbc_v : pos_v) === 1'b1) break;
      end
      if (n == 200) stop_test(1'b1);
      chk(f ? fbc_d : pos_d, e);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(`EGS_OFF_NUM, 32'h0000_0001);
      rchk(`EGS_OFF_DEN, 32'h0000_0001);
      wr(8'h3C, 32'h1234_5678);
      rchk(8'h3C, 32'h0000_0000);
      for (i = 0; i < 4; i++) begin
         wr(`EGS_OFF_UNIT, 32'(i));
         rchk(`EGS_OFF_FACTOR, fac[i]);
      end
      $display("test reset and units done");
      wr(`EGS_OFF_NUM, 32'h0000_0019);
      wr(`EGS_OFF_DEN, 32'h0000_000B);
      wr(`EGS_OFF_OD_SUB, 32'h0000_0001);
      rchk(`EGS_OFF_OD_DATA, 32'h0000_0019);
      wr(`EGS_OFF_OD_SUB, 32'h0000_0002);
      rchk(`EGS_OFF_OD_DATA, 32'h0000_000B);
      wr(`EGS_OFF_OD_DATA, 32'h0000_0002);
      rchk(`EGS_OFF_DEN, 32'h0000_0002);
      wr(`EGS_OFF_NUM, 32'h0000_0003);
      $display("test ratio setting done");
      move(1'b0, 32'h0000_000A, 32'h0000_000F);
      move(1'b0, 32'h0000_0005, 32'h0000_0007);
      move(1'b0, 32'h0000_0001, 32'h0000_0002);
      move(1'b1, 32'h0000_0009, 32'h0000_0006);
      move(1'b1, 32'h0000_0001, 32'h0000_0000);
      move(1'b1, 32'h0000_0002, 32'h0000_0002);
      $display("test scaling done");
      wr(`EGS_OFF_MASK, 32'h0000_0004);
      wr(`EGS_OFF_NUM, 32'h8000_0000);
      rchk(`EGS_OFF_NUM, 32'h0000_0003);
      rchk(`EGS_OFF_STATUS, 32'h0000_0004);
      chk(irq, 32'h0000_0001);
      wr(`EGS_OFF_MASK, 32'h0000_0000);
      rchk(`EGS_OFF_STATUS, 32'h0000_0004);
      chk(irq, 32'h0000_0000);
      wr(`EGS_OFF_STATUS, 32'h0000_0004);
      wr(`EGS_OFF_CTRL, 32'h0000_0001);
      wr(`EGS_OFF_NUM, 32'h0000_0005);
      rchk(`EGS_OFF_NUM, 32'h0000_0003);
      rchk(`EGS_OFF_STATUS, 32'h0000_0004);
      wr(`EGS_OFF_CTRL, 32'h0000_0000);
      wr(`EGS_OFF_STATUS, 32'h0000_0004);
      rchk(`EGS_OFF_STATUS, 32'h0000_0000);
      $display("test refusals done");
      wr(`EGS_OFF_NUM, 32'h0000_0001);
      wr(`EGS_OFF_SPD_LIM, 32'h0000_000A);
      wr(`EGS_OFF_FRQ_LIM, 32'h0000_000A);
      wr(`EGS_OFF_MASK, 32'h0000_0003);
      move(1'b0, 32'h0000_0064, 32'h0000_0032);
      // outlast the window: a live sum re-sets the status over a clear
      repeat (80) @(posedge clk);
      chk(ovs, 32'h0000_0001);
      chk(cfa, 32'h0000_0001);
      chk(irq, 32'h0000_0001);
      wr(`EGS_OFF_STATUS, 32'h0000_0003);
      rchk(`EGS_OFF_STATUS, 32'h0000_0000);
      chk(ovs, 32'h0000_0000);
      $display("test alarms done");
      stop_test(1'b0);
   end
endmodule
bind egs_gear_top egs_gear_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid_i),
   .cmd_ready_o(cmd_ready_o), .pos_valid_o(pos_valid_o),
   .fb_valid_i(fb_valid_i), .fb_ready_o(fb_ready_o),
   .fb_cmd_valid_o(fb_cmd_valid_o),
   .overspeed_alarm_o(overspeed_alarm_o), .engine_state_o(engine_state_o));
`default_nettype wire
